/* File: icrc_capture_reload.sv */
// APB slave for three-channel input capture with selectable timer reload trigger.
`timescale 1ns/100ps
module icrc_capture_reload #(
   parameter int unsigned CHANNELS   = icrc_pkg::NUM_CHAN,
   parameter int unsigned COUNT_BITS = icrc_pkg::COUNT_W
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [icrc_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [icrc_pkg::DATA_W-1:0]  pwdata,
   input  wire logic [3:0]                   pstrb,
   output logic      [icrc_pkg::DATA_W-1:0]  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic [icrc_pkg::COUNT_W-1:0] t2_count,
   input  wire logic                         t2_overflow,
   input  wire logic [icrc_pkg::NUM_CHAN-1:0] cap_pin,
   output logic                              t2_reload,
   output logic                              irq
);
   import icrc_pkg::*;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   generate
      if (CHANNELS != NUM_CHAN) begin : g_bad_channels
         $error("icrc_capture_reload serves exactly three capture channels");
      end
      if (COUNT_BITS != COUNT_W) begin : g_bad_count
         $error("icrc_capture_reload captures a sixteen bit count only");
      end
   endgenerate

   icrc_state_type           state_reg;
   icrc_state_type           state_next;
   logic [NUM_CHAN-1:0]      cap_event;
   logic [NUM_CHAN-1:0]      cap_level;
   logic                     reload_src;
   logic                     bus_setup;
   logic                     bus_access;
   logic                     addr_ok;
   logic [IDX_W-1:0]         reg_idx;
   logic [FLAG_W-1:0]        flag_set;
   logic [FLAG_W-1:0]        flag_clr;

   // ---------------------------------------------------------------
   // Capture channels
   // ---------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
         icrc_edge_detect u_edge (
            .pclk        (pclk),
            .presetn     (presetn),
            .pin_in      (cap_pin[ch]),
            .edge_sel    (icrc_edge_sel_type'(state_reg.cfg[CFG_CH0_LSB + 2*ch +: 2])),
            .level       (cap_level[ch]),
            .event_pulse (cap_event[ch])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Reload source selection
   // ---------------------------------------------------------------
   always_comb begin
      reload_src = 1'b0;
      // R04: reload trigger select
      case (icrc_reload_sel_type'(state_reg.cfg[CFG_RELOAD_LSB +: 2]))
         RELOAD_OVF: begin
            reload_src = t2_overflow;
         end
         RELOAD_CAP0: begin
            reload_src = cap_event[0];
         end
         RELOAD_CAP1: begin
            reload_src = cap_event[1];
         end
         RELOAD_CAP2: begin
            reload_src = cap_event[2];
         end
         default: begin
            reload_src = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   assign bus_setup  = psel & ~penable;
   assign bus_access = psel & penable & state_reg.pready;
   assign reg_idx    = paddr[IDX_W+1:2];
   assign addr_ok    = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:IDX_W+2] == '0);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next        = state_reg;
      state_next.reload = reload_src;
      flag_clr          = '0;
      // R05: channel flags set by channel events
      flag_set                = '0;
      flag_set[NUM_CHAN-1:0]  = cap_event;
      flag_set[FLAG_RELOAD]   = reload_src;

      // R08: whole count copied on the edge
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (cap_event[i]) begin
            state_next.cap[i] = t2_count;
         end
      end

      // Read data and error are prepared in the setup cycle.
      state_next.pready = bus_setup;
      if (bus_setup) begin
         state_next.prdata  = '0;
         state_next.pslverr = 1'b0;
         if (!addr_ok) begin
            state_next.pslverr = 1'b1;
         end else begin
            case (reg_idx)
               IDX_CONFIG: begin
                  state_next.prdata[7:0] = state_reg.cfg;
               end
               IDX_FLAGS: begin
                  state_next.prdata[FLAG_W-1:0] = state_reg.flags;
               end
               IDX_MASK: begin
                  state_next.prdata[FLAG_W-1:0] = state_reg.mask;
               end
               // R06: channel 2 low byte
               IDX_CAP2_LOW: begin
                  state_next.prdata[7:0] = state_reg.cap[2][7:0];
               end
               // R07: channel 2 high byte
               IDX_CAP2_HIGH: begin
                  state_next.prdata[7:0] = state_reg.cap[2][15:8];
               end
               IDX_CAP0_LOW: begin
                  state_next.prdata[7:0] = state_reg.cap[0][7:0];
               end
               IDX_CAP0_HIGH: begin
                  state_next.prdata[7:0] = state_reg.cap[0][15:8];
               end
               IDX_CAP1_LOW: begin
                  state_next.prdata[7:0] = state_reg.cap[1][7:0];
               end
               IDX_CAP1_HIGH: begin
                  state_next.prdata[7:0] = state_reg.cap[1][15:8];
               end
               default: begin
                  state_next.pslverr = 1'b1;
               end
            endcase
         end
      end

      // Writes take effect at the access edge; capture bytes ignore writes.
      if (bus_access && pwrite && !state_reg.pslverr && pstrb[0]) begin
         case (reg_idx)
            IDX_CONFIG: begin
               state_next.cfg = pwdata[7:0];
            end
            IDX_FLAGS: begin
               flag_clr = pwdata[FLAG_W-1:0];
            end
            IDX_MASK: begin
               state_next.mask = pwdata[FLAG_W-1:0];
            end
            default: begin
               state_next.mask = state_reg.mask;
            end
         endcase
      end

      // A new event outweighs a clear in the same cycle.
      state_next.flags = (state_reg.flags & ~flag_clr) | flag_set;
      state_next.irq   = |(state_next.flags & state_next.mask);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg         <= '0;
         state_reg.cfg     <= CONFIG_RESET;
         state_reg.flags   <= FLAGS_RESET;
         state_reg.mask    <= MASK_RESET;
         state_reg.cap     <= {NUM_CHAN{CAP_RESET}};
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata    = state_reg.prdata;
   assign pready    = state_reg.pready;
   assign pslverr   = state_reg.pslverr;
   assign t2_reload = state_reg.reload;
   assign irq       = state_reg.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // R01: channel 2 edge kind
   a_chan2_edge_kind: // R01
   assert property (cap_event[2] |->
      (($past(state_reg.cfg[7:6]) == EDGE_RISE) && cap_level[2]) ||
      (($past(state_reg.cfg[7:6]) == EDGE_FALL) && !cap_level[2]) ||
      ($past(state_reg.cfg[7:6]) == EDGE_BOTH))
      else $error("channel 2 captured on a deselected edge");

   // R02: channel 1 reserved code
   a_chan1_reserved: // R02
   assert property (($past(state_reg.cfg[5:4]) == EDGE_RSVD) |-> !cap_event[1])
      else $error("channel 1 captured under the reserved code");

   // R02: channel 1 falling edge
   a_chan1_falling: // R02
   assert property ($fell(cap_level[1]) && ($past(state_reg.cfg[5:4]) == EDGE_FALL)
      |-> cap_event[1])
      else $error("channel 1 missed a falling edge");

   // R03: channel 0 both edges
   a_chan0_both_edges: // R03
   assert property ($changed(cap_level[0]) && ($past(state_reg.cfg[3:2]) == EDGE_BOTH)
      |-> cap_event[0])
      else $error("channel 0 missed an edge in both-edge mode");

   // R04: overflow reload
   a_reload_overflow: // R04
   assert property ((state_reg.cfg[1:0] == RELOAD_OVF) && t2_overflow |=> t2_reload)
      else $error("overflow did not reload the timer");

   // R04: capture 2 reload
   a_reload_capture: // R04
   assert property ((state_reg.cfg[1:0] == RELOAD_CAP2) && !cap_event[2] |=> !t2_reload)
      else $error("reload without a channel 2 event");

   // R05: channel 0 flag
   a_chan0_flag_set: // R05
   assert property (cap_event[0] |=> state_reg.flags[0] && irq == state_reg.mask[0] ||
      state_reg.flags[0] && state_reg.mask[0] == 1'b0 || state_reg.flags[0] && irq)
      else $error("channel 0 event left its flag clear");

   // R06: low byte read
   a_cap2_low_read: // R06
   assert property (bus_setup && !pwrite && (paddr == {2'b00, IDX_CAP2_LOW, 2'b00})
      |=> pready && !pslverr && (prdata == {24'h000000, $past(state_reg.cap[2][7:0])}))
      else $error("channel 2 low byte read wrong");

   // R07: high byte read
   a_cap2_high_read: // R07
   assert property (bus_setup && !pwrite && (paddr == {2'b00, IDX_CAP2_HIGH, 2'b00})
      |=> pready && !pslverr && (prdata == {24'h000000, $past(state_reg.cap[2][15:8])}))
      else $error("channel 2 high byte read wrong");

   // R08: count copied whole
   a_count_copy: // R08
   assert property (cap_event[1] |=> state_reg.cap[1] == $past(t2_count) ##1
      (cap_event[1] || $stable(state_reg.cap[1])))
      else $error("capture did not hold the sampled count");

   // R01: channel 2 reserved code
   a_chan2_reserved: // R01
   assert property (($past(state_reg.cfg[7:6]) == EDGE_RSVD) |-> !cap_event[2])
      else $error("channel 2 captured under the reserved code");

   // R01: channel 2 rising edge
   a_chan2_rising: // R01
   assert property ($rose(cap_level[2]) && ($past(state_reg.cfg[7:6]) == EDGE_RISE)
      |-> cap_event[2])
      else $error("channel 2 missed a rising edge");

   // R02: channel 1 edge kind
   a_chan1_edge_kind: // R02
   assert property (cap_event[1] |->
      (($past(state_reg.cfg[5:4]) == EDGE_RISE) && cap_level[1]) ||
      (($past(state_reg.cfg[5:4]) == EDGE_FALL) && !cap_level[1]) ||
      ($past(state_reg.cfg[5:4]) == EDGE_BOTH))
      else $error("channel 1 captured on a deselected edge");

   // R02: channel 1 both edges
   a_chan1_both_edges: // R02
   assert property ($changed(cap_level[1]) && ($past(state_reg.cfg[5:4]) == EDGE_BOTH)
      |-> cap_event[1])
      else $error("channel 1 missed an edge in both-edge mode");

   // R03: channel 0 edge kind
   a_chan0_edge_kind: // R03
   assert property (cap_event[0] |->
      (($past(state_reg.cfg[3:2]) == EDGE_RISE) && cap_level[0]) ||
      (($past(state_reg.cfg[3:2]) == EDGE_FALL) && !cap_level[0]) ||
      ($past(state_reg.cfg[3:2]) == EDGE_BOTH))
      else $error("channel 0 captured on a deselected edge");

   // R03: channel 0 reserved code
   a_chan0_reserved: // R03
   assert property (($past(state_reg.cfg[3:2]) == EDGE_RSVD) |-> !cap_event[0])
      else $error("channel 0 captured under the reserved code");

   // R04: capture 0 reload
   a_reload_cap0: // R04
   assert property ((state_reg.cfg[1:0] == RELOAD_CAP0) && cap_event[0] |=> t2_reload)
      else $error("channel 0 event did not reload the timer");

   // R04: capture 1 reload
   a_reload_cap1: // R04
   assert property ((state_reg.cfg[1:0] == RELOAD_CAP1) && cap_event[1] |=> t2_reload)
      else $error("channel 1 event did not reload the timer");

   // R05: flag raised only by events
   a_chan0_flag_cause: // R05
   assert property ($rose(state_reg.flags[0]) |-> $past(cap_event[0]))
      else $error("channel 0 flag set without an event");

   // R05: flag cleared by a one
   a_chan0_flag_clear: // R05
   assert property (bus_access && pwrite && (reg_idx == IDX_FLAGS) && pstrb[0] && pwdata[0]
      && !state_reg.pslverr && !cap_event[0] |=> !state_reg.flags[0])
      else $error("channel 0 flag survived a clear");

   // R08: channel 0 count copied
   a_cap0_copy: // R08
   assert property (cap_event[0] |=> state_reg.cap[0] == $past(t2_count))
      else $error("channel 0 capture did not take the count");

   // R08: capture held between events
   a_cap2_hold: // R08
   assert property (!cap_event[2] |=> $stable(state_reg.cap[2]))
      else $error("channel 2 capture changed without an event");

   c_reload_by_ovf: cover property ((state_reg.cfg[1:0] == RELOAD_OVF) && t2_overflow);
   c_chan2_capture: cover property (cap_event[2] ##1 bus_setup && (reg_idx == IDX_CAP2_HIGH));
   c_reload_by_cap0: cover property ((state_reg.cfg[1:0] == RELOAD_CAP0) && cap_event[0]);
   c_irq_rise: cover property ($rose(irq));
   c_flag_clear: cover property (bus_access && pwrite && (reg_idx == IDX_FLAGS) ##1 !irq);

endmodule : icrc_capture_reload

/* File: icrc_pkg.sv */
// Constants, types and register layout of the input capture and reload block.
// Operation
// R01: Channel 2 edge select in config bits 7-6: 00 rising, 01 falling, 10 both, 11 no capture.
// R02: Channel 1 edge select in config bits 5-4 uses the same encoding, 11 gives no capture.
// R03: Channel 0 edge select in config bits 3-2 uses the same encoding, 11 gives no capture.
// R04: Config bits 1-0 pick the reload trigger: 00 overflow, 01 to 11 capture channel 0 to 2.
// R05: Flag bit 0 is set by a capture or reload event on channel 0.
// R06: A read-only register at index a6h returns the low byte of the channel 2 capture.
// R07: A read-only register at index a7h returns the high byte of the channel 2 capture.
// R08: A qualifying edge copies the whole 16-bit count into both capture bytes at once.
package icrc_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W   = 12;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned IDX_W    = 8;
   localparam int unsigned COUNT_W  = 16;
   localparam int unsigned NUM_CHAN = 3;
   localparam int unsigned FLAG_W   = 4;

   // ---------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_CONFIG    = 8'ha0;
   localparam logic [7:0] IDX_FLAGS     = 8'ha1;
   localparam logic [7:0] IDX_MASK      = 8'ha2;
   localparam logic [7:0] IDX_CAP2_LOW  = 8'ha6;
   localparam logic [7:0] IDX_CAP2_HIGH = 8'ha7;
   localparam logic [7:0] IDX_CAP0_LOW  = 8'ha8;
   localparam logic [7:0] IDX_CAP0_HIGH = 8'ha9;
   localparam logic [7:0] IDX_CAP1_LOW  = 8'haa;
   localparam logic [7:0] IDX_CAP1_HIGH = 8'hab;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int unsigned CFG_RELOAD_LSB = 0;
   localparam int unsigned CFG_CH0_LSB    = 2;
   localparam int unsigned CFG_CH1_LSB    = 4;
   localparam int unsigned CFG_CH2_LSB    = 6;
   localparam int unsigned FLAG_RELOAD    = 3;
   localparam logic [7:0]  CONFIG_RESET   = 8'h00;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
   localparam logic [FLAG_W-1:0] MASK_RESET  = 4'h0;
   localparam logic [COUNT_W-1:0] CAP_RESET  = 16'h0000;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      EDGE_RISE = 2'b00,
      EDGE_FALL = 2'b01,
      EDGE_BOTH = 2'b10,
      EDGE_RSVD = 2'b11
   } icrc_edge_sel_type;

   typedef enum logic [1:0] {
      RELOAD_OVF  = 2'b00,
      RELOAD_CAP0 = 2'b01,
      RELOAD_CAP1 = 2'b10,
      RELOAD_CAP2 = 2'b11
   } icrc_reload_sel_type;

   // ---------------------------------------------------------------
   // State records
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sync;
      logic       level;
      logic       event_pulse;
   } icrc_edge_state_type;

   typedef struct packed {
      logic [7:0]                       cfg;
      logic [FLAG_W-1:0]                flags;
      logic [FLAG_W-1:0]                mask;
      logic [NUM_CHAN-1:0][COUNT_W-1:0] cap;
      logic                             reload;
      logic                             irq;
      logic                             pready;
      logic                             pslverr;
      logic [DATA_W-1:0]                prdata;
   } icrc_state_type;

endpackage : icrc_pkg

/* File: icrc_edge_detect.sv */
// Pin synchroniser, change filter and edge qualifier for one capture channel.
`timescale 1ns/100ps
module icrc_edge_detect (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 pin_in,
   input  icrc_pkg::icrc_edge_sel_type edge_sel,
   output logic                      level,
   output logic                      event_pulse
);
   import icrc_pkg::*;

   icrc_edge_state_type state_reg;
   icrc_edge_state_type state_next;

   // ---------------------------------------------------------------
   // Filter and edge qualification
   // ---------------------------------------------------------------
   always_comb begin
      state_next             = state_reg;
      state_next.sync        = {state_reg.sync[1:0], pin_in};
      state_next.event_pulse = 1'b0;
      // A change counts only once the second and third stages agree.
      if ((state_reg.sync[1] == state_reg.sync[2]) && (state_reg.sync[2] != state_reg.level)) begin
         state_next.level = state_reg.sync[2];
         // R01 R02 R03: edge kind select
         case (edge_sel)
            EDGE_RISE: begin
               state_next.event_pulse = state_reg.sync[2];
            end
            EDGE_FALL: begin
               state_next.event_pulse = ~state_reg.sync[2];
            end
            EDGE_BOTH: begin
               state_next.event_pulse = 1'b1;
            end
            default: begin
               state_next.event_pulse = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign level       = state_reg.level;
   assign event_pulse = state_reg.event_pulse;

endmodule : icrc_edge_detect

/* File: icrc_timer_pins.sv */
// Timer 2 counter and capture pin model that faces the capture block.
`timescale 1ns/100ps
module icrc_timer_pins (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   input  wire logic [2:0]  pin_req,
   output logic      [15:0] t2_count,
   output logic             t2_overflow,
   output logic      [2:0]  cap_pin
);
   logic [15:0] count_reg;
   logic        ovf_reg;

   // The count can be frozen so that a capture has one known value to latch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 16'h0000;
         ovf_reg   <= 1'b0;
      end else begin
         ovf_reg <= run && !load && (count_reg == 16'hffff);
         if (load) begin
            count_reg <= load_val;
         end else if (run) begin
            count_reg <= count_reg + 16'h0001;
         end
      end
   end

   assign t2_count    = count_reg;
   assign t2_overflow = ovf_reg;
   assign cap_pin     = pin_req;
endmodule : icrc_timer_pins

/* File: input_capture_reload_control_test.sv */
// Self-checking testbench of the input capture and reload block.
`timescale 1ns/100ps
module input_capture_reload_control_test;
   import icrc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        t2_overflow, t2_reload, irq, run, load;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [15:0] t2_count, load_val;
   logic [2:0]  cap_pin, pin_req;
   logic [15:0] ec [3];
   int          failures, n_checks, cycles, rl_cnt;

   icrc_capture_reload dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .t2_count(t2_count),
      .t2_overflow(t2_overflow), .cap_pin(cap_pin), .t2_reload(t2_reload), .irq(irq));
   icrc_timer_pins model_u (.pclk(pclk), .presetn(presetn), .run(run), .load(load),
      .load_val(load_val), .pin_req(pin_req), .t2_count(t2_count),
      .t2_overflow(t2_overflow), .cap_pin(cap_pin));

   // ---------------------------------------------------------------
   // Clock, timeout and reload pulse counter
   // ---------------------------------------------------------------
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (t2_reload === 1'b1) rl_cnt++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task finish_test();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   task chk(input string name, input logic [31:0] exp_v, input logic [31:0] got);
      n_checks++;
      if (got !== exp_v) begin
         $display("Error %s expected %h seen %h", name, exp_v, got);
         failures++;
      end
   endtask : chk

   task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
            output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] d;
      logic        e;
      apb(1'b1, idx, v, d, e);
   endtask : wr

   task rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp_d,
               input logic exp_e);
      logic [31:0] d;
      logic        e;
      apb(1'b0, idx, 8'h00, d, e);
      chk(name, exp_d, d);
      chk("pslverr", {31'h0, exp_e}, {31'h0, e});
   endtask : rd_chk

   task pin_ev(input int ch, input logic v, input logic [15:0] cnt);
      @(posedge pclk);
      load        <= 1'b1;
      load_val    <= cnt;
      pin_req[ch] <= v;
      @(posedge pclk);
      load <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask : pin_ev

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      logic [15:0] v;
      logic [7:0]  ci;
      logic        q;
      int          n0;
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; pstrb = 4'hf; run = 0; load = 0; load_val = '0; pin_req = '0;
      failures = 0; n_checks = 0; cycles = 0; rl_cnt = 0;
      ec = '{16'h0000, 16'h0000, 16'h0000};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("config", IDX_CONFIG, 32'h0, 1'b0);
      rd_chk("flags", IDX_FLAGS, 32'h0, 1'b0);
      rd_chk("mask", IDX_MASK, 32'h0, 1'b0);
      wr(IDX_CAP2_LOW, 8'h5a);
      rd_chk("cap2 low", IDX_CAP2_LOW, 32'h0, 1'b0);
      rd_chk("cap2 high", IDX_CAP2_HIGH, 32'h0, 1'b0);
      rd_chk("unmapped", 8'hb0, 32'h0, 1'b1);
      $display("test reset done");
      for (int ch = 0; ch < 3; ch++) begin
         for (int code = 0; code < 4; code++) begin
            wr(IDX_CONFIG, 8'(code << (2 + 2 * ch)));
            wr(IDX_FLAGS, 8'h0f);
            for (int dir = 0; dir < 2; dir++) begin
               v = 16'(ch * 4096 + code * 256 + dir * 16 + 7);
               pin_ev(ch, (dir == 0), v);
               q = (code == 2) || (code == dir);
               if (q) ec[ch] = v;
               ci = (ch == 2) ? IDX_CAP2_LOW : 8'(IDX_CAP0_LOW + 2 * ch);
               rd_chk("flags", IDX_FLAGS, {31'h0, q} << ch, 1'b0);
               wr(IDX_FLAGS, 8'h0f);
               rd_chk("cap low", ci, {24'h0, ec[ch][7:0]}, 1'b0);
               rd_chk("cap high", ci + 8'h01, {24'h0, ec[ch][15:8]}, 1'b0);
               chk("irq", 32'h0, {31'h0, irq});
            end
         end
      end
      $display("test edges done");
      for (int r = 0; r < 4; r++) begin
         wr(IDX_CONFIG, 8'haa | 8'(r));
         n0 = rl_cnt;
         for (int ch = 0; ch < 3; ch++) pin_ev(ch, ~pin_req[ch], 16'h0100);
         @(posedge pclk);
         load     <= 1'b1;
         load_val <= 16'hfffd;
         @(posedge pclk);
         load <= 1'b0;
         run  <= 1'b1;
         repeat (6) @(posedge pclk);
         run <= 1'b0;
         repeat (4) @(posedge pclk);
         chk("reload pulses", 32'h1, 32'(rl_cnt - n0));
      end
      $display("test reload done");
      pstrb <= 4'h0;
      wr(IDX_MASK, 8'h01);
      pstrb <= 4'hf;
      rd_chk("mask strobe", IDX_MASK, 32'h0, 1'b0);
      wr(IDX_CONFIG, 8'h04);
      pin_ev(0, 1'b1, 16'h1234);
      rd_chk("cap0 kept", IDX_CAP0_LOW, 32'h0, 1'b0);
      wr(IDX_FLAGS, 8'h0f);
      wr(IDX_MASK, 8'h01);
      pin_ev(0, 1'b0, 16'hbeef);
      chk("irq", 32'h1, {31'h0, irq});
      rd_chk("flags", IDX_FLAGS, 32'h1, 1'b0);
      rd_chk("cap0 low", IDX_CAP0_LOW, 32'hef, 1'b0);
      rd_chk("cap0 high", IDX_CAP0_HIGH, 32'hbe, 1'b0);
      wr(IDX_MASK, 8'h00);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      wr(IDX_MASK, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      wr(IDX_FLAGS, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      rd_chk("flags", IDX_FLAGS, 32'h0, 1'b0);
      $display("test interrupt done");
      finish_test();
   end
endmodule : input_capture_reload_control_test
